// ==== common/pvs_pkg.sv ====
// Shared constants and types for the PV selector and contact I/O block
package pvs_pkg;
	localparam int PV_W           = 16;
	localparam int OUT_W          = 16;
	localparam int PAT_W          = 5;
	localparam int GRP_N          = 8;
	localparam int GRP_W          = 3;
	localparam int CT_W           = 16;

	localparam logic [1:0] SEL_MAX  = 2'h0;
	localparam logic [1:0] SEL_MIN  = 2'h1;
	localparam logic [1:0] SEL_AVG  = 2'h2;
	localparam logic [1:0] SEL_DIFF = 2'h3;

	localparam logic [1:0] OT_CURRENT = 2'h0;
	localparam logic [1:0] OT_PULSE   = 2'h1;
	localparam logic [1:0] OT_RELAY   = 2'h2;

	localparam logic [2:0] RT_OFF      = 3'h0;
	localparam logic [2:0] RT_PV       = 3'h1;
	localparam logic [2:0] RT_SP       = 3'h2;
	localparam logic [2:0] RT_OUT      = 3'h3;
	localparam logic [2:0] RT_LOOP_PWR = 3'h4;

	localparam logic [PAT_W-1:0] PAT_OFFSET = 5'h10;
	localparam logic [PAT_W-1:0] PAT_RESET  = 5'h01;

	// Cycle-time unit: 1 ms per count of control_cycle_time
	localparam int CT_UNIT_NS  = 1000000;
	localparam int CLK_NS      = 20;
	localparam int CT_UNIT_CYC = (CT_UNIT_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		ST_RESET,
		ST_RUN,
		ST_LOCAL
	} pvs_mode_t;
endpackage

// ==== verilog/pvs_param_mem.sv ====
`timescale 1ns/1ps
// Memory of the eight tuning groups: preset output and output limits
module pvs_param_mem
	import pvs_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	input  wire logic                 wr_en,
	input  wire logic [GRP_W-1:0]     wr_grp,
	input  wire logic [3*OUT_W-1:0]   wr_data,
	input  wire logic [GRP_W-1:0]     rd_grp,
	output logic      [3*OUT_W-1:0]   rd_data
);
	logic [3*OUT_W-1:0] mem [GRP_N];

	// Synchronous write, registered read
	always_ff @(posedge clk)
	begin
		if (rst)
			rd_data <= '0;
		else if (ce)
		begin
			if (wr_en)
				mem[wr_grp] <= wr_data;
			rd_data <= mem[rd_grp];
		end
	end
endmodule

// ==== verilog/pvs_core.sv ====
`timescale 1ns/1ps
// PV selection, contact decode, run control, output forcing and routing
module pvs_core
	import pvs_pkg::*;
(
	input  wire logic                    CLK,
	input  wire logic                    RST,
	input  wire logic                    CE,
	input  wire logic [1:0]              PV_SELECT_MODE,
	input  wire logic signed [PV_W-1:0]  PV_IN_1,
	input  wire logic signed [PV_W-1:0]  PV_IN_2,
	input  wire logic                    CONTACT_IN_1,
	input  wire logic                    CONTACT_IN_2,
	input  wire logic                    CONTACT_IN_3,
	input  wire logic                    CONTACT_IN_4,
	input  wire logic                    RUN_START_INPUT,
	input  wire logic                    RUN_STOP_INPUT,
	input  wire logic                    LOCAL_MODE_INPUT,
	input  wire logic                    PATTERN_OFFSET_INPUT,
	input  wire logic                    KEY_STOP,
	input  wire logic                    MANUAL_MODE,
	input  wire logic [OUT_W-1:0]        MANUAL_OUTPUT,
	input  wire logic [OUT_W-1:0]        CONTROL_OUTPUT,
	input  wire logic [GRP_W-1:0]        PID_GROUP,
	input  wire logic                    GROUP_WR,
	input  wire logic [GRP_W-1:0]        GROUP_WR_SEL,
	input  wire logic [OUT_W-1:0]        GROUP_PRESET,
	input  wire logic [OUT_W-1:0]        GROUP_LOW_LIMIT,
	input  wire logic [OUT_W-1:0]        GROUP_HIGH_LIMIT,
	input  wire logic                    PV_EVENT_1,
	input  wire logic                    PV_EVENT_2,
	input  wire logic                    ALARM_1,
	input  wire logic [3:0]              TIME_EVENT,
	input  wire logic [1:0]              CONTROL_OUTPUT_TYPE,
	input  wire logic [CT_W-1:0]         CONTROL_CYCLE_TIME,
	input  wire logic [2:0]              RETRANS_TYPE_FIRST,
	input  wire logic [2:0]              RETRANS_TYPE_SECOND,
	input  wire logic [OUT_W-1:0]        RETRANS_SCALE_HIGH_FIRST,
	input  wire logic [OUT_W-1:0]        RETRANS_SCALE_LOW_FIRST,
	input  wire logic [OUT_W-1:0]        RETRANS_SCALE_HIGH_SECOND,
	input  wire logic [OUT_W-1:0]        RETRANS_SCALE_LOW_SECOND,
	input  wire logic [PV_W-1:0]         PROGRAM_SETPOINT,
	output logic signed [PV_W-1:0]       PV_SELECTED,
	output logic [PAT_W-1:0]             PATTERN_NUMBER,
	output logic                         RUNNING,
	output logic                         LOCAL_MODE,
	output logic                         PRESET_FORCED,
	output logic [OUT_W-1:0]             PRIMARY_OUTPUT_VALUE,
	output logic                         PRIMARY_PULSE,
	output logic                         PRIMARY_RELAY,
	output logic                         CONTACT_OUT_1,
	output logic                         CONTACT_OUT_2,
	output logic                         CONTACT_OUT_3,
	output logic                         CONTACT_OUT_4,
	output logic                         CONTACT_OUT_5,
	output logic                         CONTACT_OUT_6,
	output logic                         CONTACT_OUT_7,
	output logic [OUT_W-1:0]             RETRANS_OUTPUT_FIRST,
	output logic                         RETRANS_FIRST_EN,
	output logic [OUT_W-1:0]             RETRANS_OUTPUT_SECOND,
	output logic                         RETRANS_SECOND_EN,
	output logic                         LOOP_POWER_EN
);
	typedef struct packed {
		logic [7:0]              sync1;
		logic [7:0]              sync2;
		logic [7:0]              prev;
		pvs_mode_t               mode;
		logic                    running;
		logic                    local_on;
		logic [PAT_W-1:0]        pattern;
		logic signed [PV_W-1:0]  pv;
		logic                    forced;
		logic [OUT_W-1:0]        out_val;
		logic [CT_W-1:0]         ct_cnt;
		logic [$clog2(CT_UNIT_CYC+1)-1:0] unit_cnt;
		logic                    pulse;
		logic                    relay;
		logic [6:0]              dout;
		logic [OUT_W-1:0]        rt1;
		logic                    rt1_en;
		logic [OUT_W-1:0]        rt2;
		logic                    rt2_en;
		logic                    loop_pwr;
	} pvs_state_t;

	pvs_state_t r;
	pvs_state_t next_r;
	logic [3*OUT_W-1:0] grp_rd;
	logic [OUT_W-1:0]   grp_preset;
	logic [OUT_W-1:0]   grp_low;
	logic [OUT_W-1:0]   grp_high;

	// Scale a 0..full-range value between a low and high limit
	function automatic logic [OUT_W-1:0] scale(input logic [OUT_W-1:0] v,
		input logic [OUT_W-1:0] lo, input logic [OUT_W-1:0] hi);
		logic signed [2*OUT_W+1:0] span;
		logic signed [2*OUT_W+1:0] prod;
		span = $signed({2'b00, {OUT_W{1'b0}}, hi}) - $signed({2'b00, {OUT_W{1'b0}}, lo});
		prod = (span * $signed({2'b00, {OUT_W{1'b0}}, v})) >>> OUT_W;
		return OUT_W'(prod + $signed({2'b00, {OUT_W{1'b0}}, lo}));
	endfunction

	// Clamp within output limits
	function automatic logic [OUT_W-1:0] clamp(input logic [OUT_W-1:0] v,
		input logic [OUT_W-1:0] lo, input logic [OUT_W-1:0] hi);
		if (v < lo)
			return lo;
		if (v > hi)
			return hi;
		return v;
	endfunction

	// Tuning group storage
	pvs_param_mem u_mem (
		.clk     (CLK),
		.rst     (RST),
		.ce      (CE),
		.wr_en   (GROUP_WR),
		.wr_grp  (GROUP_WR_SEL),
		.wr_data ({GROUP_HIGH_LIMIT, GROUP_LOW_LIMIT, GROUP_PRESET}),
		.rd_grp  (PID_GROUP),
		.rd_data (grp_rd)
	);

	assign grp_preset = grp_rd[OUT_W-1:0];
	assign grp_low    = grp_rd[2*OUT_W-1:OUT_W];
	assign grp_high   = grp_rd[3*OUT_W-1:2*OUT_W];

	// Next-state logic
	always_comb
	begin
		logic [7:0]             rise;
		logic [3:0]             sel;
		logic signed [PV_W:0]   sum;
		logic [OUT_W-1:0]       out_src;
		rise      = '0;
		sel       = '0;
		sum       = '0;
		out_src   = '0;
		next_r    = r;

		// Two-flop sampling of contact inputs
		next_r.sync1 = {PATTERN_OFFSET_INPUT, LOCAL_MODE_INPUT, RUN_STOP_INPUT,
			RUN_START_INPUT, CONTACT_IN_4, CONTACT_IN_3, CONTACT_IN_2, CONTACT_IN_1};
		next_r.sync2 = r.sync1;
		next_r.prev  = r.sync2;
		rise         = r.sync2 & ~r.prev;

		// PV selection
		sum = $signed({PV_IN_1[PV_W-1], PV_IN_1}) + $signed({PV_IN_2[PV_W-1], PV_IN_2});
		case (PV_SELECT_MODE)
			SEL_MAX:  next_r.pv = (PV_IN_1 > PV_IN_2) ? PV_IN_1 : PV_IN_2;
			SEL_MIN:  next_r.pv = (PV_IN_1 < PV_IN_2) ? PV_IN_1 : PV_IN_2;
			SEL_AVG:  next_r.pv = PV_W'(sum >>> 1);
			SEL_DIFF: next_r.pv = PV_W'(PV_IN_2 - PV_IN_1);
			default:  next_r.pv = PV_IN_1;
		endcase

		// Pattern decode, only in reset state
		sel = r.sync2[3:0];
		if (r.mode == ST_RESET && sel != 4'h0)
			next_r.pattern = {1'b0, sel} + (r.sync2[7] ? PAT_OFFSET : '0);

		// Operation mode
		case (r.mode)
			ST_RESET:
			begin
				if (rise[4])
					next_r.mode = ST_RUN;
				else if (rise[6])
					next_r.mode = ST_LOCAL;
			end
			ST_RUN:
			begin
				if (rise[5] || KEY_STOP)
					next_r.mode = ST_RESET;
				else if (rise[6])
					next_r.mode = ST_LOCAL;
			end
			ST_LOCAL:
			begin
				if (rise[5] || KEY_STOP)
					next_r.mode = ST_RESET;
				else if (rise[4])
					next_r.mode = ST_RUN;
			end
			default: next_r.mode = ST_RESET;
		endcase

		// Output value: preset wins over manual when stopped
		next_r.forced = (next_r.mode == ST_RESET);
		next_r.running  = (next_r.mode == ST_RUN);
		next_r.local_on = (next_r.mode == ST_LOCAL);
		if (r.forced)
			out_src = grp_preset;
		else if (MANUAL_MODE)
			out_src = MANUAL_OUTPUT;
		else
			out_src = CONTROL_OUTPUT;
		next_r.out_val = clamp(out_src, grp_low, grp_high);

		// Time-proportioned pulse for pulse and relay output types
		next_r.unit_cnt = r.unit_cnt + 1'b1;
		if (r.unit_cnt >= ($bits(r.unit_cnt))'(CT_UNIT_CYC - 1))
		begin
			next_r.unit_cnt = '0;
			next_r.ct_cnt   = r.ct_cnt + 1'b1;
			if (r.ct_cnt + 1'b1 >= CONTROL_CYCLE_TIME)
			begin
				next_r.ct_cnt = '0;
			end
		end
		next_r.pulse = (CONTROL_CYCLE_TIME != '0) &&
			(OUT_W'((32'(r.ct_cnt) << OUT_W) / (32'(CONTROL_CYCLE_TIME) + 1))
				< r.out_val);
		next_r.relay = next_r.pulse && (CONTROL_OUTPUT_TYPE == OT_RELAY);
		if (CONTROL_OUTPUT_TYPE != OT_PULSE)
			next_r.pulse = 1'b0;

		// Contact outputs
		next_r.dout = {TIME_EVENT, ALARM_1, PV_EVENT_2, PV_EVENT_1};

		// First retransmission and loop power
		next_r.loop_pwr = (RETRANS_TYPE_FIRST == RT_LOOP_PWR)
			|| (RETRANS_TYPE_SECOND == RT_LOOP_PWR);
		next_r.rt1_en = (RETRANS_TYPE_FIRST == RT_PV || RETRANS_TYPE_FIRST == RT_SP
			|| RETRANS_TYPE_FIRST == RT_OUT) && !next_r.loop_pwr;
		case (RETRANS_TYPE_FIRST)
			RT_PV:   next_r.rt1 = scale(r.pv, RETRANS_SCALE_LOW_FIRST,
				RETRANS_SCALE_HIGH_FIRST);
			RT_SP:   next_r.rt1 = scale(PROGRAM_SETPOINT, RETRANS_SCALE_LOW_FIRST,
				RETRANS_SCALE_HIGH_FIRST);
			RT_OUT:  next_r.rt1 = scale(r.out_val, RETRANS_SCALE_LOW_FIRST,
				RETRANS_SCALE_HIGH_FIRST);
			default: next_r.rt1 = '0;
		endcase
		if (!next_r.rt1_en)
			next_r.rt1 = '0;

		// Second retransmission on primary terminal, relay type only
		next_r.rt2_en = (CONTROL_OUTPUT_TYPE == OT_RELAY)
			&& (RETRANS_TYPE_SECOND == RT_PV || RETRANS_TYPE_SECOND == RT_SP
			|| RETRANS_TYPE_SECOND == RT_OUT);
		case (RETRANS_TYPE_SECOND)
			RT_PV:   next_r.rt2 = scale(r.pv, RETRANS_SCALE_LOW_SECOND,
				RETRANS_SCALE_HIGH_SECOND);
			RT_SP:   next_r.rt2 = scale(PROGRAM_SETPOINT, RETRANS_SCALE_LOW_SECOND,
				RETRANS_SCALE_HIGH_SECOND);
			RT_OUT:  next_r.rt2 = scale(r.out_val, RETRANS_SCALE_LOW_SECOND,
				RETRANS_SCALE_HIGH_SECOND);
			default: next_r.rt2 = '0;
		endcase
		if (!next_r.rt2_en)
			next_r.rt2 = '0;
	end

	// State register with clock enable
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			r         <= '0;
			r.mode    <= ST_RESET;
			r.pattern <= PAT_RESET;
			r.forced  <= 1'b1;
		end
		else if (CE)
			r <= next_r;
	end

	// Outputs straight from state flops
	assign PV_SELECTED           = r.pv;
	assign PATTERN_NUMBER        = r.pattern;
	assign RUNNING               = r.running;
	assign LOCAL_MODE            = r.local_on;
	assign PRESET_FORCED         = r.forced;
	assign PRIMARY_OUTPUT_VALUE  = r.out_val;
	assign PRIMARY_PULSE         = r.pulse;
	assign PRIMARY_RELAY         = r.relay;
	assign CONTACT_OUT_1         = r.dout[0];
	assign CONTACT_OUT_2         = r.dout[1];
	assign CONTACT_OUT_3         = r.dout[2];
	assign CONTACT_OUT_4         = r.dout[3];
	assign CONTACT_OUT_5         = r.dout[4];
	assign CONTACT_OUT_6         = r.dout[5];
	assign CONTACT_OUT_7         = r.dout[6];
	assign RETRANS_OUTPUT_FIRST  = r.rt1;
	assign RETRANS_FIRST_EN      = r.rt1_en;
	assign RETRANS_OUTPUT_SECOND = r.rt2;
	assign RETRANS_SECOND_EN     = r.rt2_en;
	assign LOOP_POWER_EN         = r.loop_pwr;
endmodule

// ==== tb/pvs_core_asserts.sv ====
// Concurrent checks on the PV selector and contact I/O block
`timescale 1ns/1ps
module pvs_core_asserts
(
	input wire logic                           CLK,
	input wire logic                           RST,
	input wire logic                           CE,
	input wire logic [1:0]                     PV_SELECT_MODE,
	input wire logic signed [pvs_pkg::PV_W-1:0] PV_IN_1,
	input wire logic signed [pvs_pkg::PV_W-1:0] PV_IN_2,
	input wire logic signed [pvs_pkg::PV_W-1:0] PV_SELECTED,
	input wire logic                           RUN_START_INPUT,
	input wire logic                           RUN_STOP_INPUT,
	input wire logic                           LOCAL_MODE_INPUT,
	input wire logic                           KEY_STOP,
	input wire logic                           RUNNING,
	input wire logic                           LOCAL_MODE,
	input wire logic                           PRESET_FORCED
);
	import pvs_pkg::*;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// Selected PV one cycle after its inputs
	property p_sel_max;
		CE && PV_SELECT_MODE == SEL_MAX |=> PV_SELECTED ==
			($past(PV_IN_1) > $past(PV_IN_2) ? $past(PV_IN_1) : $past(PV_IN_2));
	endproperty
	a_sel_max: assert property (p_sel_max) else $error("max select wrong");
	property p_sel_min;
		CE && PV_SELECT_MODE == SEL_MIN |=> PV_SELECTED ==
			($past(PV_IN_1) < $past(PV_IN_2) ? $past(PV_IN_1) : $past(PV_IN_2));
	endproperty
	a_sel_min: assert property (p_sel_min) else $error("min select wrong");
	// Even inputs keep the mean exact
	property p_sel_avg;
		CE && PV_SELECT_MODE == SEL_AVG && !PV_IN_1[0] && !PV_IN_2[0] |=>
			PV_SELECTED == ($past(PV_IN_1) >>> 1) + ($past(PV_IN_2) >>> 1);
	endproperty
	a_sel_avg: assert property (p_sel_avg) else $error("mean select wrong");
	property p_sel_diff;
		CE && PV_SELECT_MODE == SEL_DIFF |=> PV_SELECTED == $past(PV_IN_2) - $past(PV_IN_1);
	endproperty
	a_sel_diff: assert property (p_sel_diff) else $error("difference wrong");
	// Contact edges and a held stop key act within a few cycles
	property p_start;
		$rose(RUN_START_INPUT) && !RUNNING && !KEY_STOP |-> ##[2:5] RUNNING;
	endproperty
	a_start: assert property (p_start) else $error("start edge ignored");
	property p_stop;
		$rose(RUN_STOP_INPUT) && RUNNING |-> ##[2:5] (!RUNNING && PRESET_FORCED);
	endproperty
	a_stop: assert property (p_stop) else $error("stop edge ignored");
	property p_local;
		$rose(LOCAL_MODE_INPUT) && !KEY_STOP && !RUN_STOP_INPUT |-> ##[2:5] LOCAL_MODE;
	endproperty
	a_local: assert property (p_local) else $error("local edge ignored");
	property p_key_stop;
		KEY_STOP [*3] |-> ##[0:3] (PRESET_FORCED && !RUNNING);
	endproperty
	a_key_stop: assert property (p_key_stop) else $error("key stop no preset");
	// Main scenarios reached
	c_run: cover property (RUNNING ##1 !RUNNING);
	c_local: cover property (LOCAL_MODE);
	c_diff: cover property (PV_SELECT_MODE == SEL_DIFF);
endmodule
bind pvs_core pvs_core_asserts u_chk (.*);

// ==== tb/pvs_contacts.sv ====
// Contact switch model driving the block's contact inputs
`timescale 1ns/1ps
module pvs_contacts
(
	input  wire logic CLK,
	output logic      CONTACT_IN_1,
	output logic      CONTACT_IN_2,
	output logic      CONTACT_IN_3,
	output logic      CONTACT_IN_4,
	output logic      PATTERN_OFFSET_INPUT,
	output logic      RUN_START_INPUT,
	output logic      RUN_STOP_INPUT,
	output logic      LOCAL_MODE_INPUT
);
	// All switches open at power-up
	initial
	begin
		{PATTERN_OFFSET_INPUT, CONTACT_IN_4, CONTACT_IN_3, CONTACT_IN_2, CONTACT_IN_1} = 5'h00;
		{LOCAL_MODE_INPUT, RUN_STOP_INPUT, RUN_START_INPUT} = 3'h0;
	end
	// Selector switches move off the sampling edge
	task set_pattern(input logic [4:0] pat);
		@(negedge CLK);
		{PATTERN_OFFSET_INPUT, CONTACT_IN_4, CONTACT_IN_3, CONTACT_IN_2, CONTACT_IN_1} = pat;
	endtask
	// Button closed four cycles, then open four so the edge re-arms
	task push(input logic [2:0] btn);
		@(negedge CLK);
		{LOCAL_MODE_INPUT, RUN_STOP_INPUT, RUN_START_INPUT} = btn;
		repeat (4) @(negedge CLK);
		{LOCAL_MODE_INPUT, RUN_STOP_INPUT, RUN_START_INPUT} = 3'h0;
		repeat (4) @(negedge CLK);
	endtask
endmodule

// ==== tb/tb_pvs_core.sv ====
// Self-checking testbench for the PV selector and contact I/O block
`timescale 1ns/1ps
module tb_pvs_core;
	import pvs_pkg::*;
	logic                   CLK = 1'h0;
	logic                   RST = 1'h1;
	logic                   CE = 1'h1;
	logic                   KEY_STOP, MANUAL_MODE, GROUP_WR, PV_EVENT_1, PV_EVENT_2, ALARM_1;
	logic [1:0]             PV_SELECT_MODE, CONTROL_OUTPUT_TYPE;
	logic signed [PV_W-1:0] PV_IN_1, PV_IN_2, PV_SELECTED;
	logic [OUT_W-1:0]       MANUAL_OUTPUT, CONTROL_OUTPUT, GROUP_PRESET, GROUP_LOW_LIMIT;
	logic [OUT_W-1:0]       GROUP_HIGH_LIMIT, PROGRAM_SETPOINT, PRIMARY_OUTPUT_VALUE;
	logic [OUT_W-1:0]       RETRANS_SCALE_HIGH_FIRST, RETRANS_SCALE_LOW_FIRST, RETRANS_OUTPUT_FIRST;
	logic [OUT_W-1:0]       RETRANS_SCALE_HIGH_SECOND, RETRANS_SCALE_LOW_SECOND, RETRANS_OUTPUT_SECOND;
	logic [GRP_W-1:0]       PID_GROUP, GROUP_WR_SEL;
	logic [3:0]             TIME_EVENT;
	logic [CT_W-1:0]        CONTROL_CYCLE_TIME;
	logic [2:0]             RETRANS_TYPE_FIRST, RETRANS_TYPE_SECOND;
	logic [PAT_W-1:0]       PATTERN_NUMBER;
	logic                   CONTACT_IN_1, CONTACT_IN_2, CONTACT_IN_3, CONTACT_IN_4;
	logic                   RUN_START_INPUT, RUN_STOP_INPUT, LOCAL_MODE_INPUT, PATTERN_OFFSET_INPUT;
	logic                   RUNNING, LOCAL_MODE, PRESET_FORCED, PRIMARY_PULSE, PRIMARY_RELAY;
	logic                   CONTACT_OUT_1, CONTACT_OUT_2, CONTACT_OUT_3, CONTACT_OUT_4;
	logic                   CONTACT_OUT_5, CONTACT_OUT_6, CONTACT_OUT_7;
	logic                   RETRANS_FIRST_EN, RETRANS_SECOND_EN, LOOP_POWER_EN;
	logic [31:0]            seed = 32'hd6ce_98af;
	logic [31:0]            r;
	logic signed [PV_W-1:0] hold;
	logic [OUT_W-1:0]       want;
	int                     fails = 0;
	int                     compares = 0;

	// 50 MHz clock
	always #10 CLK = ~CLK;

	pvs_core     uut (.*);
	pvs_contacts sw (.*);

	// Repeatable xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected selected PV for a mode
	function automatic logic signed [PV_W-1:0] pv_exp(input logic [1:0] m,
		input logic signed [PV_W-1:0] a, input logic signed [PV_W-1:0] b);
		case (m)
			SEL_MAX: return (a > b) ? a : b;
			SEL_MIN: return (a < b) ? a : b;
			SEL_AVG: return PV_W'(((PV_W+1)'(a) + (PV_W+1)'(b)) >>> 1); // Mean rounds down
			default: return b - a;
		endcase
	endfunction

	// Expected retransmission: low plus span times value over full range
	function automatic logic [OUT_W-1:0] scale_exp(input logic [OUT_W-1:0] v,
		input logic [OUT_W-1:0] lo, input logic [OUT_W-1:0] hi);
		longint d;
		d = (longint'(hi) - longint'(lo)) * longint'(v);
		return OUT_W'(longint'(lo) + (d >>> OUT_W));
	endfunction

	// Compare, count and report
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask

	task tally_and_finish();
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Reset, then scenarios
	initial
	begin
		{KEY_STOP, MANUAL_MODE, GROUP_WR, PV_EVENT_1, PV_EVENT_2, ALARM_1, TIME_EVENT} = '0;
		{PV_SELECT_MODE, PV_IN_1, PV_IN_2, MANUAL_OUTPUT, CONTROL_OUTPUT, PROGRAM_SETPOINT} = '0;
		{GROUP_PRESET, GROUP_LOW_LIMIT, GROUP_HIGH_LIMIT, PID_GROUP, GROUP_WR_SEL} = '0;
		{RETRANS_SCALE_HIGH_FIRST, RETRANS_SCALE_LOW_FIRST, RETRANS_SCALE_HIGH_SECOND} = '0;
		{RETRANS_SCALE_LOW_SECOND, RETRANS_TYPE_FIRST, RETRANS_TYPE_SECOND} = '0;
		CONTROL_OUTPUT_TYPE = OT_CURRENT;
		CONTROL_CYCLE_TIME = 16'h0001;
		repeat (6) @(negedge CLK);
		RST = 1'h0;
		chk(PRESET_FORCED, 1, "preset after reset");
		// One distinct preset per tuning group
		for (int g = 0; g < GRP_N; g++)
		begin
			GROUP_WR = 1'h1;
			GROUP_WR_SEL = g[GRP_W-1:0];
			GROUP_PRESET = {g[7:0], 8'h55};
			GROUP_LOW_LIMIT = {g[7:0], 8'h10};
			GROUP_HIGH_LIMIT = {g[7:0], 8'hf0};
			@(negedge CLK);
		end
		GROUP_WR = 1'h0;
		// Random PV pairs and events, extremes first
		for (int i = 0; i < 60; i++)
		begin
			r = rnd();
			PV_SELECT_MODE = (i < 4) ? i[1:0] : r[1:0];
			PV_IN_1 = (i < 4) ? -16'sh2000 : {{3{r[15]}}, r[15:3]};
			PV_IN_2 = (i < 4) ? 16'sh1ffe : {{3{r[31]}}, r[31:20], r[3]};
			{PV_EVENT_1, PV_EVENT_2, ALARM_1, TIME_EVENT, MANUAL_MODE} = r[11:4];
			{MANUAL_OUTPUT, CONTROL_OUTPUT} = rnd();
			{PROGRAM_SETPOINT, RETRANS_SCALE_HIGH_FIRST} = rnd();
			{RETRANS_SCALE_LOW_FIRST, RETRANS_SCALE_HIGH_SECOND} = rnd();
			RETRANS_SCALE_LOW_SECOND = r[31:16];
			@(negedge CLK);
			chk(PV_SELECTED, pv_exp(PV_SELECT_MODE, PV_IN_1, PV_IN_2), "pv select");
			chk({CONTACT_OUT_7, CONTACT_OUT_6, CONTACT_OUT_5, CONTACT_OUT_4, CONTACT_OUT_3,
				CONTACT_OUT_2, CONTACT_OUT_1}, {TIME_EVENT, ALARM_1, PV_EVENT_2, PV_EVENT_1},
				"contact out");
		end
		// Enable low freezes the selected PV, high resumes it
		hold = pv_exp(PV_SELECT_MODE, PV_IN_1, PV_IN_2);
		CE = 1'h0;
		PV_IN_1 = ~PV_IN_1;
		PV_IN_2 = ~PV_IN_2;
		repeat (3) @(negedge CLK);
		chk(PV_SELECTED, hold, "frozen by enable");
		CE = 1'h1;
		hold = pv_exp(PV_SELECT_MODE, PV_IN_1, PV_IN_2);
		@(negedge CLK);
		chk(PV_SELECTED, hold, "enable resumes");
		// Every pattern with and without offset
		for (int p = 1; p < 32; p++)
		begin
			sw.set_pattern(p[4:0]);
			repeat (5) @(negedge CLK);
			chk(PATTERN_NUMBER, (p == 16) ? 15 : p, "pattern");
		end
		sw.set_pattern(5'h00);
		repeat (5) @(negedge CLK);
		chk(PATTERN_NUMBER, 31, "all off keeps");
		sw.set_pattern(5'h05);
		sw.push(3'h1);
		chk(RUNNING, 1, "start");
		chk(PRESET_FORCED, 0, "preset off in run");
		sw.set_pattern(5'h19);
		repeat (5) @(negedge CLK);
		chk(PATTERN_NUMBER, 5, "select while running");
		PID_GROUP = 3'h3;
		MANUAL_MODE = 1'h1;
		MANUAL_OUTPUT = 16'hffff;
		sw.push(3'h2);
		chk(RUNNING, 0, "stop");
		chk(PRESET_FORCED, 1, "preset on stop");
		chk(PRIMARY_OUTPUT_VALUE, 16'h0355, "preset over manual");
		chk(PATTERN_NUMBER, 25, "select in reset");
		sw.push(3'h4);
		chk(LOCAL_MODE, 1, "local");
		chk(PRIMARY_OUTPUT_VALUE, 16'h03f0, "manual clamped high");
		sw.push(3'h1);
		chk(RUNNING, 1, "start from local");
		KEY_STOP = 1'h1;
		repeat (6) @(negedge CLK);
		chk(PRESET_FORCED, 1, "key stop");
		chk(RUNNING, 0, "key stop halts");
		chk(PRIMARY_OUTPUT_VALUE, 16'h0355, "key stop preset");
		KEY_STOP = 1'h0;
		// Retransmission and loop power selection
		CONTROL_OUTPUT_TYPE = OT_RELAY;
		for (int t = 0; t < 5; t++)
		begin
			RETRANS_TYPE_FIRST = t[2:0];
			repeat (2) @(negedge CLK);
			chk(LOOP_POWER_EN, t == 4, "loop power");
			chk(RETRANS_FIRST_EN, t inside {1, 2, 3}, "retrans one");
		end
		RETRANS_TYPE_FIRST = RT_PV;
		RETRANS_TYPE_SECOND = RT_LOOP_PWR;
		repeat (2) @(negedge CLK);
		chk(LOOP_POWER_EN, 1, "loop power on two");
		chk(RETRANS_FIRST_EN, 0, "retrans one off");
		RETRANS_TYPE_FIRST = RT_SP;
		RETRANS_TYPE_SECOND = RT_PV;
		for (int o = 0; o < 3; o++)
		begin
			CONTROL_OUTPUT_TYPE = o[1:0];
			repeat (2) @(negedge CLK);
			chk(RETRANS_SECOND_EN, o == 2, "retrans two");
			chk(PRIMARY_RELAY, o == 2, "relay type");
			chk(PRIMARY_PULSE, o == 1, "pulse type");
			want = scale_exp(PROGRAM_SETPOINT, RETRANS_SCALE_LOW_FIRST, RETRANS_SCALE_HIGH_FIRST);
			chk(RETRANS_OUTPUT_FIRST, want, "retrans one value");
			want = (o == 2) ? scale_exp(pv_exp(PV_SELECT_MODE, PV_IN_1, PV_IN_2),
				RETRANS_SCALE_LOW_SECOND, RETRANS_SCALE_HIGH_SECOND) : '0;
			chk(RETRANS_OUTPUT_SECOND, want, "retrans two value");
		end
		// Zero cycle time disables the pulse
		CONTROL_OUTPUT_TYPE = OT_PULSE;
		CONTROL_CYCLE_TIME = 16'h0000;
		repeat (2) @(negedge CLK);
		chk(PRIMARY_PULSE, 0, "pulse off at zero cycle");
		tally_and_finish();
	end
endmodule
